// >>> adsc_regs.vh
`ifndef ADSC_REGS_VH
`define ADSC_REGS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADSC_CTRL0_ADDR   12'h000
`define ADSC_CTRL1_ADDR   12'h004
`define ADSC_CTRL2_ADDR   12'h008
`define ADSC_RES_HI_ADDR  12'h00C
`define ADSC_RES_LO_ADDR  12'h010
`define ADSC_FLAG_ADDR    12'h014
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADSC_C0_ON_BIT    0
`define ADSC_C0_GO_BIT    1
`define ADSC_C0_CH_LSB    2
`define ADSC_C0_CH_MSB    5
`define ADSC_C1_NREF_BIT  5
`define ADSC_C1_PREF_BIT  4
`define ADSC_C2_JUST_BIT  7
`define ADSC_C2_ACQ_MSB   5
`define ADSC_C2_ACQ_LSB   3
`define ADSC_C2_CLK_MSB   2
`define ADSC_C2_CLK_LSB   0
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define ADSC_CTRL0_RST    6'h00
`define ADSC_CTRL2_RST    8'h00
`define ADSC_PCFG_FUSE1   4'h0
`define ADSC_PCFG_FUSE0   4'h7
`define ADSC_PCFG_ALLA    4'h2
`define ADSC_CONV_TADS    5'h0D
`define ADSC_GAP_TADS     5'h02
`define ADSC_BITS         4'hC
`endif

// >>> adsc_res_mem.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Result pair store, no reset by design
// ----------------------------------------
module adsc_res_mem (
  input  wire        pclk,
  input  wire        wr_en,
  input  wire [15:0] wr_data,
  output reg  [15:0] rd_data
);
  // Kept across ordinary resets; undefined only after power-up
  always @(posedge pclk) begin
    if (wr_en) begin
      rd_data <= wr_data;
    end
  end
endmodule // adsc_res_mem
`default_nettype wire

// >>> adsc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "adsc_regs.vh"
module adsc_top #(
  parameter TCY_CLKS = 4,
  parameter RC_DIV   = 625
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        por_event,
  input  wire        portb_analog_default_fuse,
  input  wire        sleep_mode,
  input  wire        rc_osc_tick,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        sar_dac_load,
  output reg  [11:0] sar_trial,
  input  wire        sar_comp_hi,
  output reg         sample_switch,
  output reg  [3:0]  sample_channel,
  output reg         neg_ref_from_pin,
  output reg         pos_ref_from_pin,
  output reg  [12:0] channel_analog,
  output reg         conversion_done_flag
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_RCD  = 3'h1;
  localparam ST_ACQ  = 3'h2;
  localparam ST_CONV = 3'h3;
  localparam ST_GAP  = 3'h4;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [4:0] acq_tads;
    input [2:0] code;
    begin
      case (code)
        3'h0: acq_tads = 5'h00;
        3'h1: acq_tads = 5'h02;
        3'h2: acq_tads = 5'h04;
        3'h3: acq_tads = 5'h06;
        3'h4: acq_tads = 5'h08;
        3'h5: acq_tads = 5'h0C;
        3'h6: acq_tads = 5'h10;
        default: acq_tads = 5'h14;
      endcase
    end
  endfunction

  function [6:0] clk_div;
    input [2:0] code;
    begin
      case (code)
        3'h0: clk_div = 7'h02;
        3'h1: clk_div = 7'h08;
        3'h2: clk_div = 7'h20;
        3'h4: clk_div = 7'h04;
        3'h5: clk_div = 7'h10;
        3'h6: clk_div = 7'h40;
        default: clk_div = 7'h00;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg        on_r;
  reg        go_r;
  reg  [3:0] chan_r;
  reg        nref_r;
  reg        pref_r;
  reg  [3:0] pcfg_r;
  reg  [7:0] ctrl2_r;
  reg  [2:0] st_r;
  reg  [6:0] div_r;
  reg  [9:0] rcd_r;
  reg  [4:0] tad_cnt_r;
  reg  [3:0] bit_r;
  reg        load_r;
  wire [15:0] res_q;
  wire        is_rc   = (ctrl2_r[1:0] == 2'h3);
  wire        wr      = psel & penable & pwrite;
  wire        rd      = psel & ~penable & ~pwrite;
  wire        go_set  = wr && (paddr == `ADSC_CTRL0_ADDR) && pwdata[`ADSC_C0_GO_BIT];
  wire        flag_wr = wr && (paddr == `ADSC_FLAG_ADDR);
  reg         tad_tick;
  reg  [15:0] res_d;
  integer     i;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign sar_dac_load = (st_r == ST_CONV) & tad_tick;

  // ----------------------------------------
  // Bit period tick
  // ----------------------------------------
  // RC ticks come from the analog oscillator, so sleep does not stop it
  always @* begin
    if (is_rc) begin
      tad_tick = rc_osc_tick;
    end else begin
      // Oscillator divider stalls in sleep; only the RC clock runs on
      tad_tick = !sleep_mode &&
                 (div_r == clk_div(ctrl2_r[`ADSC_C2_CLK_MSB:`ADSC_C2_CLK_LSB]) - 7'h01);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 7'h00;
    end else if (st_r == ST_IDLE || tad_tick) begin
      div_r <= 7'h00;
    end else if (!sleep_mode) begin
      div_r <= div_r + 7'h01;
    end
  end

  // ----------------------------------------
  // APB register writes
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_r    <= 1'b0;
      chan_r  <= 4'h0;
      nref_r  <= 1'b0;
      pref_r  <= 1'b0;
      ctrl2_r <= `ADSC_CTRL2_RST;
      pcfg_r  <= `ADSC_PCFG_FUSE1;
      conversion_done_flag <= 1'b0;
    end else begin
      if (por_event) begin
        pcfg_r <= portb_analog_default_fuse ? `ADSC_PCFG_FUSE1 : `ADSC_PCFG_FUSE0;
      end else if (wr && paddr == `ADSC_CTRL1_ADDR) begin
        pcfg_r <= pwdata[3:0];
      end
      if (wr && paddr == `ADSC_CTRL0_ADDR) begin
        on_r   <= pwdata[`ADSC_C0_ON_BIT];
        chan_r <= pwdata[`ADSC_C0_CH_MSB:`ADSC_C0_CH_LSB];
      end
      if (wr && paddr == `ADSC_CTRL1_ADDR) begin
        nref_r <= pwdata[`ADSC_C1_NREF_BIT];
        pref_r <= pwdata[`ADSC_C1_PREF_BIT];
      end
      if (wr && paddr == `ADSC_CTRL2_ADDR) begin
        ctrl2_r <= pwdata[7:0] & 8'hBF;
      end
      // Set wins over a software clear in the same cycle
      if (load_r) begin
        conversion_done_flag <= 1'b1;
      end else if (flag_wr) begin
        conversion_done_flag <= pwdata[0];
      end
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= ST_IDLE;
      go_r      <= 1'b0;
      rcd_r     <= 10'h000;
      tad_cnt_r <= 5'h00;
      bit_r     <= 4'h0;
      sar_trial <= 12'h000;
      load_r    <= 1'b0;
    end else begin
      load_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (go_set && on_r) begin
            go_r      <= 1'b1;
            rcd_r     <= 10'h000;
            tad_cnt_r <= acq_tads(ctrl2_r[`ADSC_C2_ACQ_MSB:`ADSC_C2_ACQ_LSB]);
            st_r      <= is_rc ? ST_RCD : ST_ACQ;
          end
        end
        ST_RCD: begin
          rcd_r <= rcd_r + 10'h001;
          if (rcd_r == TCY_CLKS[9:0] - 10'h001) begin
            st_r <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (tad_cnt_r == 5'h00) begin
            st_r      <= ST_CONV;
            tad_cnt_r <= `ADSC_CONV_TADS;
            bit_r     <= `ADSC_BITS - 4'h1;
            sar_trial <= 12'h800;
          end else if (tad_tick) begin
            tad_cnt_r <= tad_cnt_r - 5'h01;
          end
        end
        ST_CONV: begin
          if (tad_tick) begin
            tad_cnt_r <= tad_cnt_r - 5'h01;
            // First period only tracks the hold; the last one decides bit 0
            if (tad_cnt_r != `ADSC_CONV_TADS) begin
              // Keep or drop the trial bit, then try the next one
              if (!sar_comp_hi) begin
                sar_trial[bit_r] <= 1'b0;
              end
              if (bit_r != 4'h0) begin
                sar_trial[bit_r - 4'h1] <= 1'b1;
                bit_r <= bit_r - 4'h1;
              end
            end
            if (tad_cnt_r == 5'h01) begin
              go_r      <= 1'b0;
              load_r    <= 1'b1;
              tad_cnt_r <= `ADSC_GAP_TADS;
              st_r      <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          // Holds off a restart for the minimum gap
          if (tad_tick) begin
            tad_cnt_r <= tad_cnt_r - 5'h01;
            if (tad_cnt_r == 5'h01) begin
              st_r <= ST_IDLE;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
      if (!on_r) begin
        st_r <= ST_IDLE;
        go_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Result store and pin controls
  // ----------------------------------------
  always @* begin
    if (ctrl2_r[`ADSC_C2_JUST_BIT]) begin
      res_d = {4'h0, sar_trial};
    end else begin
      res_d = {sar_trial, 4'h0};
    end
  end

  adsc_res_mem u_res (
    .pclk    (pclk),
    .wr_en   (load_r),
    .wr_data (res_d),
    .rd_data (res_q)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_switch    <= 1'b0;
      sample_channel   <= 4'h0;
      neg_ref_from_pin <= 1'b0;
      pos_ref_from_pin <= 1'b0;
      channel_analog   <= 13'h1FFF;
    end else begin
      // Open the switch on the same edge that starts the conversion
      sample_switch    <= on_r && (st_r != ST_CONV) &&
                          !(st_r == ST_ACQ && tad_cnt_r == 5'h00);
      sample_channel   <= chan_r;
      neg_ref_from_pin <= nref_r;
      pos_ref_from_pin <= pref_r;
      for (i = 0; i < 13; i = i + 1) begin
        // Code 3 frees channel 12, each step one lower
        channel_analog[i] <= (pcfg_r <= `ADSC_PCFG_ALLA) ||
                             ({1'b0, pcfg_r} < (5'h0F - i[4:0]));
      end
    end
  end

  // ----------------------------------------
  // APB read data
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      case (paddr)
        `ADSC_CTRL0_ADDR:  prdata <= {26'h0, chan_r, go_r, on_r};
        `ADSC_CTRL1_ADDR:  prdata <= {26'h0, nref_r, pref_r, pcfg_r};
        `ADSC_CTRL2_ADDR:  prdata <= {24'h0, ctrl2_r};
        `ADSC_RES_HI_ADDR: prdata <= {24'h0, res_q[15:8]};
        `ADSC_RES_LO_ADDR: prdata <= {24'h0, res_q[7:0]};
        `ADSC_FLAG_ADDR:   prdata <= {31'h0, conversion_done_flag};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // adsc_top
`default_nettype wire

// >>> adsc_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "adsc_regs.vh"
module adsc_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        por_event,
  input wire logic        portb_analog_default_fuse,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        sar_dac_load,
  input wire logic        sample_switch,
  input wire logic        neg_ref_from_pin,
  input wire logic        pos_ref_from_pin,
  input wire logic [12:0] channel_analog,
  input wire logic        conversion_done_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       wr;
  logic [5:0] c1_r;
  logic [3:0] pc_d_r;
  logic [2:0] acq_r;
  logic [4:0] nld_r;
  assign wr = psel && penable && pwrite;
  function automatic logic [12:0] amap(input logic [3:0] c);
    amap = (c > 4'h2) ? (13'h1FFF >> (c - 4'h2)) : 13'h1FFF;
  endfunction
  // ----------------------------------------
  // Shadow of the written configuration
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_r   <= 6'h00;
      pc_d_r <= 4'h0;
      acq_r  <= 3'h0;
      nld_r  <= 5'h00;
    end else begin
      pc_d_r <= c1_r[3:0];
      if (por_event) begin
        c1_r[3:0] <= portb_analog_default_fuse ? 4'h0 : 4'h7;
      end else if (wr && paddr == `ADSC_CTRL1_ADDR) begin
        c1_r <= pwdata[5:0];
      end
      if (wr && paddr == `ADSC_CTRL2_ADDR) begin
        acq_r <= pwdata[5:3];
      end
      if (wr && paddr == `ADSC_CTRL0_ADDR && pwdata[1]) begin
        nld_r <= 5'h00;
      end else if (sar_dac_load) begin
        nld_r <= nld_r + 5'h01;
      end
    end
  end
  a_neg_ref: assert property (wr && paddr == `ADSC_CTRL1_ADDR
    |=> ##[0:1] neg_ref_from_pin == c1_r[5]) else $error("negative reference select wrong");
  a_pos_ref: assert property (wr && paddr == `ADSC_CTRL1_ADDR
    |=> ##[0:1] pos_ref_from_pin == c1_r[4]) else $error("positive reference select wrong");
  a_pin_map: assert property (pc_d_r == c1_r[3:0]
    |-> channel_analog == amap(c1_r[3:0])) else $error("analog pin map wrong");
  a_load_count: assert property ($rose(conversion_done_flag)
    |-> nld_r == 5'd13) else $error("bit period count per conversion wrong");
  a_load_in_conv: assert property (sar_dac_load |-> !sample_switch)
    else $error("trial load while sampling");
  a_sample_resume: assert property ($rose(conversion_done_flag)
    |-> ##[1:600] sample_switch) else $error("sampling did not resume");
  a_unmapped_zero: assert property (psel && penable && !pwrite
    && paddr > `ADSC_FLAG_ADDR |-> prdata == 32'h0) else $error("unmapped read not zero");
  a_acq_zero: assert property (wr && paddr == `ADSC_CTRL0_ADDR && pwdata[1]
    && acq_r == 3'h0 && sample_switch |=> ##[0:2] !sample_switch) else $error("late start");
endmodule // adsc_props
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "adsc_regs.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error at %0t got %h expected %h", $time, (a), (b)); end end
module testbench;
  logic        pclk, presetn, por_event, portb_analog_default_fuse, sleep_mode;
  logic        rc_osc_tick, psel, penable, pwrite, sar_comp_hi, pready, pslverr;
  logic        sar_dac_load, sample_switch, neg_ref_from_pin, pos_ref_from_pin;
  logic        conversion_done_flag;
  logic [3:0]  sample_channel, ch;
  logic [11:0] paddr, sar_trial, tgt;
  logic [12:0] channel_analog;
  logic [15:0] ex;
  logic [31:0] pwdata, prdata, rd, rnd, cyc;
  int          n_mismatch, compares, n, c, nl;
  int          dv [8] = '{2, 8, 32, 8, 4, 16, 64, 8};
  int          aq [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  adsc_top uut (.*);
  // Ideal comparator standing in for the analog input
  assign sar_comp_hi = (tgt >= sar_trial);
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  // Free-running internal RC tick, one every eight clocks
  always @(posedge pclk) begin
    cyc <= cyc + 32'h1;
    rc_osc_tick <= (cyc[2:0] == 3'h0);
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [12:0] amap(input logic [3:0] c);
    amap = (c > 4'h2) ? (13'h1FFF >> (c - 4'h2)) : 13'h1FFF;
  endfunction
  task automatic give_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic fail_out;
    n_mismatch++;
    give_verdict;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int j;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    j = 0;
    do begin
      @(posedge pclk);
      j++;
    end while (pready !== 1'b1 && j < 20);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (j >= 20) fail_out;
  endtask
  // Wait on flag (s=1) or sampling switch (s=0), counting trial loads
  task automatic wt(input int s, input logic v, output int k);
    k = 0;
    do begin
      @(negedge pclk);
      k++;
      nl += int'(sar_dac_load);
      if (k > 4000) fail_out;
    end while ((s ? conversion_done_flag : sample_switch) !== v);
  endtask
  initial begin
    {presetn, por_event, portb_analog_default_fuse, sleep_mode, psel, penable, pwrite} = 7'h0;
    {paddr, pwdata, tgt, cyc, n_mismatch, compares} = '0;
    rnd = 32'hB08AB040;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (n = 0; n < 2; n++) begin
      @(posedge pclk);
      portb_analog_default_fuse <= n[0];
      por_event <= 1'b1;
      @(posedge pclk);
      por_event <= 1'b0;
      repeat (2) @(negedge pclk);
      `CHK(channel_analog, n ? 13'h1FFF : 13'h00FF)
    end
    for (n = 0; n < 16; n++) begin
      rnd = lfsr(rnd);
      apb(1'b1, `ADSC_CTRL1_ADDR, {rnd[31:4], n[3:0]});
      apb(1'b0, `ADSC_CTRL1_ADDR, 32'h0);
      `CHK(rd, {26'h0, rnd[5:4], n[3:0]})
      `CHK({neg_ref_from_pin, pos_ref_from_pin, channel_analog}, {rnd[5:4], amap(n[3:0])})
    end
    apb(1'b0, 12'h100, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(pslverr, 1'b0)
    for (n = 0; n < 8; n++) begin
      rnd = lfsr(rnd);
      ch = rnd[15:12] % 4'hD;
      ex = rnd[16] ? {4'h0, rnd[11:0]} : {rnd[11:0], 4'h0};
      @(posedge pclk);
      tgt <= rnd[11:0];
      sleep_mode <= n[0] & n[1];
      apb(1'b1, `ADSC_CTRL1_ADDR, 32'h0);
      apb(1'b1, `ADSC_CTRL2_ADDR, {24'h0, rnd[16], 1'b0, n[2:0], n[2:0]});
      apb(1'b1, `ADSC_CTRL0_ADDR, {26'h0, ch, 2'b01});
      apb(1'b1, `ADSC_CTRL0_ADDR, {26'h0, ch, 2'b11});
      nl = 0;
      wt(0, 1'b0, c);
      `CHK(c + dv[n] >= aq[n] * dv[n] && c <= aq[n] * dv[n] + dv[n] + 12, 1'b1)
      `CHK(sample_channel, ch)
      wt(1, 1'b1, c);
      `CHK(nl, 13)
      apb(1'b0, `ADSC_CTRL0_ADDR, 32'h0);
      `CHK(rd[1:0], 2'b01)
      apb(1'b0, `ADSC_RES_HI_ADDR, 32'h0);
      `CHK(rd, {24'h0, ex[15:8]})
      apb(1'b0, `ADSC_RES_LO_ADDR, 32'h0);
      `CHK(rd, {24'h0, ex[7:0]})
      apb(1'b1, `ADSC_FLAG_ADDR, 32'h0);
      wt(0, 1'b1, c);
      `CHK(conversion_done_flag, 1'b0)
      `CHK(channel_analog[ch], 1'b1)
      // Minimum gap before the next start, else go is ignored
      repeat (2 * dv[n] + 2) @(posedge pclk);
    end
    apb(1'b1, `ADSC_CTRL2_ADDR, 32'h36);
    apb(1'b1, `ADSC_CTRL0_ADDR, 32'h1);
    apb(1'b1, `ADSC_CTRL0_ADDR, 32'h3);
    repeat (100) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK({sample_switch, conversion_done_flag, channel_analog}, {2'b00, 13'h1FFF})
    apb(1'b0, `ADSC_CTRL0_ADDR, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, `ADSC_RES_HI_ADDR, 32'h0);
    `CHK(rd, {24'h0, ex[15:8]})
    give_verdict;
  end
endmodule // testbench
bind adsc_top adsc_props u_props (.*);
`default_nettype wire
